//--- src/rec_local_end.sv
// Purpose: Local reservation logic end; fills in and streams the reservation element
// Assumes: Control inputs come from logic on i_core_clk
// Notes:   Allocation table must not be written while o_busy is high

`timescale 1ns/100ps

// Behaviour
// - Id, length 5+4N, control, beam, address, allocations
// - Control bit positions fixed from bit 15 down
// - Type codes 0..4, 5..7 reserved
// - Stream index reserved for foreign beacon type
// - Reason codes 0..5, reserved for foreign type
// - Owner negotiating or maintaining sends reason zero
// - Removed slots or merged elements send modified
// - Target reports interference with reason five
// - Status clear negotiating, set when established
// - Status always one for foreign beacon type
// - Owner bit marks owner; reserved for foreign
// - Tie-breaker drawn randomly, held for reservation
// - Address names peer; reserved for foreign type
// - Unsafe set when any slot exceeds limits
// - Unidirectional only for no-acknowledge-only traffic
// - Waveform meaningful for hard and contention types
// - Beam copied from beacon sent to target
// - Sixteen zones of sixteen slot units
// - Allocation is zone bitmap then slot bitmap
// - Slot bit reserves unit in each flagged zone
// - At least one allocation; any consistent count (local end sends at most 8)
module rec_local_end
  import rec_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_send,
  input  wire logic                  i_new_request,
  input  wire logic [2:0]            i_rsv_type,
  input  wire logic [2:0]            i_stream_idx,
  input  wire logic                  i_is_owner,
  input  wire logic [1:0]            i_phase,
  input  wire logic [2:0]            i_verdict,
  input  wire logic                  i_modified,
  input  wire logic                  i_interfered,
  input  wire logic                  i_noack_only,
  input  wire logic                  i_type_a,
  input  wire logic                  i_ofdm,
  input  wire logic [7:0]            i_beacon_beam,
  input  wire logic [15:0]           i_target_addr,
  input  wire logic [15:0]           i_owner_addr,
  input  wire logic                  i_alloc_wr,
  input  wire logic [REC_AIDX_W-1:0] i_alloc_idx,
  input  wire logic [15:0]           i_alloc_zone,
  input  wire logic [15:0]           i_alloc_slot,
  input  wire logic [REC_CNT_W-1:0]  i_alloc_cnt,
  input  wire logic [REC_MAP_W-1:0]  i_limit_map,
  rec_link_if.src                    lnk,
  output logic                       o_busy,
  output logic                       o_done,
  output logic                       o_tie,
  output logic                       o_unsafe
);

  // ****************************************
  // Types and storage
  // ****************************************
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PREP = 2'b01,
    S_SEND = 2'b11
  } rec_tx_e;

  rec_tx_e              state_r;
  rec_tx_e              state_nxt;
  logic [15:0]          zone_r [REC_MAX_ALLOC];
  logic [15:0]          slot_r [REC_MAX_ALLOC];
  logic [15:0]          lfsr_r;
  logic                 tie_r;
  logic [15:0]          ctrl_r;
  logic [7:0]           beam_r;
  logic [15:0]          addr_r;
  logic [REC_CNT_W-1:0] cnt_r;
  logic [7:0]           idx_r;
  logic                 valid_r;
  logic                 last_r;
  logic [7:0]           data_r;
  logic                 done_r;
  logic                 busy_r;
  logic                 unsafe_r;

  // ****************************************
  // Field policy
  // ****************************************
  wire logic                 is_foreign;
  wire logic                 is_wave_type;
  wire logic                 is_estab;
  wire logic [2:0]           reason_w;
  wire logic                 status_w;
  wire logic                 wave_w;
  wire logic [15:0]          addr_w;
  wire logic [15:0]          ctrl_w;
  wire logic [REC_CNT_W-1:0] cnt_w;
  wire logic [7:0]           len_w;
  wire logic [7:0]           last_ix;
  wire logic                 fill;
  wire logic [7:0]           aoff;
  wire logic [REC_AIDX_W-1:0] aent;
  logic [REC_MAP_W-1:0]      alloc_map;
  logic [7:0]                octet_w;

  assign is_foreign   = (i_rsv_type == REC_T_FOREIGN);
  assign is_wave_type = (i_rsv_type == REC_T_HARD) || (i_rsv_type == REC_T_CONT);
  assign is_estab     = (i_phase == REC_P_ESTABLISHED);

  // Modified outranks interference: the reduction has already been applied
  assign reason_w = is_foreign                ? REC_R_ACCEPTED :
                    i_modified                ? REC_R_MODIFIED :
                    (!i_is_owner && i_interfered && !is_estab)
                                              ? REC_R_INTERFERED :
                    (!i_is_owner && !is_estab) ? i_verdict :
                                                REC_R_ACCEPTED;

  assign status_w = is_foreign | is_estab;
  // Type B has no second waveform, so the OFDM one is never sent
  assign wave_w   = is_wave_type & i_type_a & i_ofdm;
  assign addr_w   = is_foreign ? 16'h0000 :
                    (i_is_owner ? i_target_addr : i_owner_addr);

  assign ctrl_w = {1'b0,
                   wave_w,
                   i_noack_only,
                   unsafe_r,
                   tie_r,
                   i_is_owner & ~is_foreign,
                   status_w,
                   reason_w,
                   is_foreign ? 3'h0 : i_stream_idx,
                   i_rsv_type};

  // Never fewer than one allocation on the air
  assign cnt_w   = (i_alloc_cnt == '0) ? REC_CNT_MIN :
                   (i_alloc_cnt > REC_CNT_MAX) ? REC_CNT_MAX : i_alloc_cnt;
  assign len_w   = REC_LEN_BASE + {2'b00, cnt_r, 2'b00};
  assign last_ix = len_w + 8'h01;
  assign aoff    = idx_r - REC_HDR_OCTETS;
  assign aent    = aoff[REC_AIDX_W+1:2];
  assign fill    = (state_r == S_SEND) && (!valid_r || lnk.ready);

  // Union of the valid allocation entries over the superframe
  always_comb begin
    alloc_map = '0;
    for (int i = 0; i < REC_MAX_ALLOC; i++) begin
      if (REC_CNT_W'(i) < cnt_w) begin
        alloc_map = alloc_map | rec_expand(zone_r[i], slot_r[i]);
      end
    end
  end

  // Octet order: id, length, control, beam, address, then zone and slot
  always_comb begin
    unique case (idx_r)
      REC_IX_ID:     octet_w = REC_ELEM_ID;
      REC_IX_LEN:    octet_w = len_w;
      REC_IX_CTL_LO: octet_w = ctrl_r[7:0];
      REC_IX_CTL_HI: octet_w = ctrl_r[15:8];
      REC_IX_BEAM:   octet_w = beam_r;
      REC_IX_ADR_LO: octet_w = addr_r[7:0];
      REC_IX_ADR_HI: octet_w = addr_r[15:8];
      default: begin
        unique case (aoff[1:0])
          2'h0:    octet_w = zone_r[aent][7:0];
          2'h1:    octet_w = zone_r[aent][15:8];
          2'h2:    octet_w = slot_r[aent][7:0];
          default: octet_w = slot_r[aent][15:8];
        endcase
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (i_send) begin
          state_nxt = S_PREP;
        end
      end
      S_PREP: state_nxt = S_SEND;
      S_SEND: begin
        if (valid_r && lnk.ready && last_r) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lfsr_r <= REC_LFSR_SEED;
      tie_r  <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      if (i_new_request) begin
        tie_r <= lfsr_r[0];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int i = 0; i < REC_MAX_ALLOC; i++) begin
        zone_r[i] <= 16'h0000;
        slot_r[i] <= 16'h0000;
      end
      unsafe_r <= 1'b0;
    end else begin
      if (i_alloc_wr) begin
        zone_r[i_alloc_idx] <= i_alloc_zone;
        slot_r[i_alloc_idx] <= i_alloc_slot;
      end
      unsafe_r <= |(alloc_map & i_limit_map);
    end
  end

  // Fields are frozen for the whole element
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_r <= 16'h0000;
      beam_r <= 8'h00;
      addr_r <= 16'h0000;
      cnt_r  <= REC_CNT_MIN;
    end else if (state_r == S_IDLE && i_send) begin
      ctrl_r <= ctrl_w;
      beam_r <= i_beacon_beam;
      addr_r <= addr_w;
      cnt_r  <= cnt_w;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= S_IDLE;
      idx_r   <= 8'h00;
      valid_r <= 1'b0;
      last_r  <= 1'b0;
      data_r  <= 8'h00;
      done_r  <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Busy mirrors the next state so the output leaves a flop
      busy_r  <= (state_nxt != S_IDLE);
      done_r  <= valid_r && lnk.ready && last_r;
      if (state_r == S_PREP) begin
        idx_r <= 8'h00;
      end else if (fill) begin
        if (valid_r && last_r) begin
          valid_r <= 1'b0;
          last_r  <= 1'b0;
        end else begin
          valid_r <= 1'b1;
          data_r  <= octet_w;
          last_r  <= (idx_r == last_ix);
          idx_r   <= idx_r + 8'h01;
        end
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign lnk.valid = valid_r;
  assign lnk.last  = last_r;
  assign lnk.data  = data_r;
  assign o_busy    = busy_r;
  assign o_done    = done_r;
  assign o_tie     = tie_r;
  assign o_unsafe  = unsafe_r;

endmodule

//--- src/rec_pkg.sv
// Purpose: Shared constants, types and helpers for the slot reservation element codec
// Assumes: One MAC clock, octets travel least significant octet first
// Notes:   Both ends import this package whole

package rec_pkg;

  // ****************************************
  // Element layout
  // ****************************************
  localparam logic [7:0] REC_ELEM_ID      = 8'h10;  // Element id value, arbitrary
  localparam logic [7:0] REC_LEN_BASE     = 8'h05;
  localparam logic [7:0] REC_LEN_MIN      = 8'h09;
  localparam logic [1:0] REC_LEN_MOD      = 2'h1;
  localparam logic [7:0] REC_HDR_OCTETS   = 8'h07;
  localparam int         REC_MAX_ALLOC    = 8;
  localparam int         REC_AIDX_W       = 3;
  localparam int         REC_CNT_W        = 4;
  localparam logic [3:0] REC_CNT_MAX      = 4'h8;
  localparam logic [3:0] REC_CNT_MIN      = 4'h1;

  // Octet positions inside the element
  localparam logic [7:0] REC_IX_ID        = 8'h00;
  localparam logic [7:0] REC_IX_LEN       = 8'h01;
  localparam logic [7:0] REC_IX_CTL_LO    = 8'h02;
  localparam logic [7:0] REC_IX_CTL_HI    = 8'h03;
  localparam logic [7:0] REC_IX_BEAM      = 8'h04;
  localparam logic [7:0] REC_IX_ADR_LO    = 8'h05;
  localparam logic [7:0] REC_IX_ADR_HI    = 8'h06;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int REC_B_RSVD    = 15;
  localparam int REC_B_WAVE    = 14;
  localparam int REC_B_UNI     = 13;
  localparam int REC_B_UNSAFE  = 12;
  localparam int REC_B_TIE     = 11;
  localparam int REC_B_OWNER   = 10;
  localparam int REC_B_STATUS  = 9;
  localparam int REC_F_REASON  = 6;
  localparam int REC_F_STREAM  = 3;
  localparam int REC_F_TYPE    = 0;

  // ****************************************
  // Zone structure
  // ****************************************
  localparam int REC_ZONES     = 16;
  localparam int REC_SLOTS     = 16;
  localparam int REC_MAP_W     = REC_ZONES * REC_SLOTS;

  localparam logic [15:0] REC_LFSR_SEED = 16'hace1;

  typedef enum logic [2:0] {
    REC_T_FOREIGN = 3'h0,
    REC_T_HARD    = 3'h1,
    REC_T_CONT    = 3'h2,
    REC_T_PRIVATE = 3'h3,
    REC_T_ABSENCE = 3'h4
  } rec_type_e;

  typedef enum logic [2:0] {
    REC_R_ACCEPTED   = 3'h0,
    REC_R_CONFLICT   = 3'h1,
    REC_R_PENDING    = 3'h2,
    REC_R_DENIED     = 3'h3,
    REC_R_MODIFIED   = 3'h4,
    REC_R_INTERFERED = 3'h5
  } rec_reason_e;

  typedef enum logic [1:0] {
    REC_P_NEGOTIATE   = 2'h0,
    REC_P_CONFLICT    = 2'h1,
    REC_P_ESTABLISHED = 2'h3
  } rec_phase_e;

  // Spread one allocation field over the whole superframe
  function automatic logic [REC_MAP_W-1:0] rec_expand(input logic [15:0] zone,
                                                     input logic [15:0] slot);
    logic [REC_MAP_W-1:0] m;
    m = '0;
    for (int z = 0; z < REC_ZONES; z++) begin
      if (zone[z]) begin
        m[z*REC_SLOTS +: REC_SLOTS] = slot;
      end
    end
    return m;
  endfunction

endpackage

//--- src/rec_link_if.sv
// Purpose: Octet stream carrying one element from the local end to the peer end
// Assumes: Both ends on the same clock
// Notes:   An octet moves on a cycle with valid and ready both high

`timescale 1ns/100ps

interface rec_link_if;
  logic       valid;
  logic       last;
  logic [7:0] data;
  logic       ready;

  modport src (output valid, output last, output data, input ready);
  modport snk (input valid, input last, input data, output ready);
endinterface

//--- src/rec_peer_end.sv
// Purpose: Peer end; parses a received reservation element into fields and a slot map
// Assumes: Octets arrive on the same clock as this logic
// Notes:   Malformed elements raise o_err and leave the last good fields in place

`timescale 1ns/100ps

module rec_peer_end
  import rec_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  rec_link_if.snk                   lnk,
  output logic                      o_done,
  output logic                      o_err,
  output logic [2:0]                o_rsv_type,
  output logic [2:0]                o_stream_idx,
  output logic [2:0]                o_reason,
  output logic                      o_status,
  output logic                      o_owner,
  output logic                      o_tie,
  output logic                      o_unsafe,
  output logic                      o_unidir,
  output logic                      o_wave,
  output logic [7:0]                o_beam,
  output logic [15:0]               o_peer_addr,
  output logic [5:0]                o_alloc_cnt,
  output logic [REC_MAP_W-1:0]      o_slot_map
);

  // ****************************************
  // Capture
  // ****************************************
  logic [7:0]           idx_r;
  logic                 id_ok_r;
  logic [7:0]           len_r;
  logic [15:0]          ctrl_r;
  logic [7:0]           beam_r;
  logic [15:0]          addr_r;
  logic [15:0]          zone_r;
  logic [7:0]           slot_lo_r;
  logic [REC_MAP_W-1:0] acc_r;
  logic                 ready_r;
  logic                 done_r;
  logic                 err_r;
  logic [15:0]          f_ctrl_r;
  logic [7:0]           f_beam_r;
  logic [15:0]          f_addr_r;
  logic [7:0]           f_len_r;
  logic [REC_MAP_W-1:0] f_map_r;

  wire logic                 take;
  wire logic [7:0]           aoff;
  wire logic                 len_ok;
  wire logic                 good;
  wire logic [REC_MAP_W-1:0] acc_nxt;
  wire logic                 f_foreign;
  wire logic                 f_wave_type;
  wire logic [7:0]           f_cnt8;

  assign take    = lnk.valid & ready_r;
  assign aoff    = idx_r - REC_HDR_OCTETS;
  // Any count that fits the length octet is taken, no upper table limit
  assign len_ok  = (len_r >= REC_LEN_MIN) && (len_r[1:0] == REC_LEN_MOD);
  assign good    = id_ok_r && len_ok && (idx_r == len_r + 8'h01);
  assign acc_nxt = acc_r | rec_expand(zone_r, {lnk.data, slot_lo_r});

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ready_r   <= 1'b0;
      idx_r     <= 8'h00;
      id_ok_r   <= 1'b0;
      len_r     <= 8'h00;
      ctrl_r    <= 16'h0000;
      beam_r    <= 8'h00;
      addr_r    <= 16'h0000;
      zone_r    <= 16'h0000;
      slot_lo_r <= 8'h00;
      acc_r     <= '0;
      done_r    <= 1'b0;
      err_r     <= 1'b0;
      f_ctrl_r  <= 16'h0000;
      f_beam_r  <= 8'h00;
      f_addr_r  <= 16'h0000;
      f_len_r   <= REC_LEN_BASE;
      f_map_r   <= '0;
    end else begin
      ready_r <= 1'b1;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      if (take) begin
        idx_r <= lnk.last ? 8'h00 : idx_r + 8'h01;
        unique case (idx_r)
          REC_IX_ID:     id_ok_r       <= (lnk.data == REC_ELEM_ID);
          REC_IX_LEN:    len_r         <= lnk.data;
          REC_IX_CTL_LO: ctrl_r[7:0]   <= lnk.data;
          REC_IX_CTL_HI: ctrl_r[15:8]  <= lnk.data;
          REC_IX_BEAM:   beam_r        <= lnk.data;
          REC_IX_ADR_LO: addr_r[7:0]   <= lnk.data;
          REC_IX_ADR_HI: addr_r[15:8]  <= lnk.data;
          default: begin
            unique case (aoff[1:0])
              2'h0:    zone_r[7:0]  <= lnk.data;
              2'h1:    zone_r[15:8] <= lnk.data;
              2'h2:    slot_lo_r    <= lnk.data;
              default: acc_r        <= acc_nxt;
            endcase
          end
        endcase
        if (lnk.last) begin
          acc_r <= '0;
          if (good) begin
            done_r   <= 1'b1;
            f_ctrl_r <= ctrl_r;
            f_beam_r <= beam_r;
            f_addr_r <= addr_r;
            f_len_r  <= len_r;
            f_map_r  <= acc_nxt;
          end else begin
            err_r <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Decoded fields, reserved parts ignored
  // ****************************************
  assign f_foreign   = (f_ctrl_r[REC_F_TYPE +: 3] == REC_T_FOREIGN);
  assign f_wave_type = (f_ctrl_r[REC_F_TYPE +: 3] == REC_T_HARD) ||
                       (f_ctrl_r[REC_F_TYPE +: 3] == REC_T_CONT);
  assign f_cnt8      = (f_len_r - REC_LEN_BASE) >> 2;

  assign lnk.ready    = ready_r;
  assign o_done       = done_r;
  assign o_err        = err_r;
  assign o_rsv_type   = f_ctrl_r[REC_F_TYPE +: 3];
  assign o_stream_idx = f_foreign ? 3'h0 : f_ctrl_r[REC_F_STREAM +: 3];
  assign o_reason     = f_foreign ? 3'h0 : f_ctrl_r[REC_F_REASON +: 3];
  assign o_status     = f_ctrl_r[REC_B_STATUS];
  assign o_owner      = f_foreign ? 1'b0 : f_ctrl_r[REC_B_OWNER];
  assign o_tie        = f_ctrl_r[REC_B_TIE];
  assign o_unsafe     = f_ctrl_r[REC_B_UNSAFE];
  assign o_unidir     = f_ctrl_r[REC_B_UNI];
  assign o_wave       = f_wave_type & f_ctrl_r[REC_B_WAVE];
  assign o_beam       = f_beam_r;
  assign o_peer_addr  = f_foreign ? 16'h0000 : f_addr_r;
  assign o_alloc_cnt  = f_cnt8[5:0];
  assign o_slot_map   = f_map_r;

endmodule

//--- tb/rec_link_chk.sv
// Purpose: Protocol checks on the element octet stream
// Assumes: One clock, synchronous active high reset
// Notes:   Octet position is counted here, not taken from either end

`timescale 1ns/100ps

module rec_link_chk
  import rec_pkg::*;
(
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       valid,
  input wire logic       last,
  input wire logic [7:0] data,
  input wire logic       ready
);
  // ****************************************
  // Octet position tracking
  // ****************************************
  logic [7:0] idx_r;
  logic [7:0] len_r;
  logic [7:0] ctl_r;
  wire        take = valid && ready;
  wire        at_hi = take && idx_r == 8'h03;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      idx_r <= 8'h00;
    end else if (take) begin
      idx_r <= last ? 8'h00 : idx_r + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (take && idx_r == 8'h01) begin
      len_r <= data;
    end
    if (take && idx_r == 8'h02) begin
      ctl_r <= data;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_first;
    take && idx_r == 8'h00;
  endsequence
  // Header octets flow with no bubble while ready stays high
  sequence s_hdr;
    take [*6];
  endsequence

  a_id_first:   assert property (s_first |-> data == REC_ELEM_ID)
    else $error("element id wrong");
  a_hdr_flow:   assert property (s_first |=> s_hdr)
    else $error("header octets not back to back");
  a_len_form:   assert property (take && idx_r == 8'h01 |->
    data[1:0] == 2'h1 && data >= 8'h09)
    else $error("length octet malformed");
  a_last_pos:   assert property (take |->
    last == (idx_r > 8'h01 && {1'b0, idx_r} == {1'b0, len_r} + 9'h001))
    else $error("last octet misplaced");
  a_type_legal: assert property (take && idx_r == 8'h02 |-> data[2:0] <= 3'h4)
    else $error("reserved type sent");
  a_reason_ok:  assert property (at_hi |-> {data[0], ctl_r[7:6]} <= 3'h5)
    else $error("reserved reason sent");
  a_rsvd_zero:  assert property (at_hi |-> !data[7])
    else $error("reserved control bit set");
  a_foreign_bits: assert property (at_hi && ctl_r[2:0] == 3'h0 |->
    data[1] && !data[2] && !data[0] && ctl_r[7:3] == 5'h00)
    else $error("foreign type control bits wrong");
  a_wave_gate:  assert property (at_hi && !(ctl_r[2:0] inside {3'h1, 3'h2}) |->
    !data[6])
    else $error("waveform set for other type");
endmodule

//--- tb/testbench.sv
// Purpose: Drives the local end, checks fields decoded by the peer end
// Assumes: Peer ready is high after reset, so the link never stalls
// Notes:   Expected fields are rebuilt here from the element rules

`timescale 1ns/100ps

module testbench
  import rec_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk = 0, rst = 1, send = 0, newr = 0, own = 0, mdf = 0, itf = 0, nak = 0;
  logic ta = 0, ofdm = 0, awr = 0;
  logic [2:0] typ = 0, stm = 0, vrd = 0, aidx = 0;
  logic [1:0] ph = 0;
  logic [3:0] cnt = 0;
  logic [7:0] beam = 0;
  logic [15:0] tadr = 0, oadr = 0, az = 0, as = 0;
  logic [255:0] lim = 0;
  logic [15:0] zt[8], st[8];
  wire l_busy, l_done, l_tie, l_uns, p_done, p_err, p_st, p_ow, p_tie, p_uns, p_ud, p_wv;
  wire [2:0] p_typ, p_stm, p_rsn;
  wire [7:0] p_beam;
  wire [15:0] p_adr;
  wire [5:0] p_cnt;
  wire [255:0] p_map;
  int err_count = 0, check_count = 0;
  logic tie0;

  rec_link_if rec_link_if_i ();
  rec_local_end rec_local_end_i (.i_core_clk(clk), .i_rst(rst), .i_send(send),
    .i_new_request(newr), .i_rsv_type(typ), .i_stream_idx(stm), .i_is_owner(own),
    .i_phase(ph), .i_verdict(vrd), .i_modified(mdf), .i_interfered(itf),
    .i_noack_only(nak), .i_type_a(ta), .i_ofdm(ofdm), .i_beacon_beam(beam),
    .i_target_addr(tadr), .i_owner_addr(oadr), .i_alloc_wr(awr), .i_alloc_idx(aidx),
    .i_alloc_zone(az), .i_alloc_slot(as), .i_alloc_cnt(cnt), .i_limit_map(lim),
    .lnk(rec_link_if_i.src), .o_busy(l_busy), .o_done(l_done), .o_tie(l_tie),
    .o_unsafe(l_uns));
  rec_peer_end rec_peer_end_i (.i_core_clk(clk), .i_rst(rst), .lnk(rec_link_if_i.snk),
    .o_done(p_done), .o_err(p_err), .o_rsv_type(p_typ), .o_stream_idx(p_stm),
    .o_reason(p_rsn), .o_status(p_st), .o_owner(p_ow), .o_tie(p_tie), .o_unsafe(p_uns),
    .o_unidir(p_ud), .o_wave(p_wv), .o_beam(p_beam), .o_peer_addr(p_adr),
    .o_alloc_cnt(p_cnt), .o_slot_map(p_map));
  rec_link_chk rec_link_chk_i (.i_core_clk(clk), .i_rst(rst), .valid(rec_link_if_i.valid),
    .last(rec_link_if_i.last), .data(rec_link_if_i.data), .ready(rec_link_if_i.ready));

  initial begin
    forever #4 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [255:0] e, logic [255:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(logic [2:0] i, logic [15:0] z, logic [15:0] s);
    @(negedge clk);
    awr = 1; aidx = i; az = z; as = s; zt[i] = z; st[i] = s;
    @(negedge clk);
    awr = 0;
  endtask

  // Send one element and compare every decoded field
  task automatic go();
    logic [255:0] m;
    int n, i;
    logic f;
    n = (cnt == 0) ? 1 : (cnt > 8) ? 8 : int'(cnt);
    m = '0;
    f = (typ == 3'h0);
    for (i = 0; i < n; i++)
      for (int z = 0; z < 16; z++) if (zt[i][z]) m[z*16+:16] = m[z*16+:16] | st[i];
    repeat (2) @(negedge clk);
    send = 1;
    @(negedge clk);
    send = 0;
    chk("busy", 1, l_busy);
    for (i = 0; i < 60 && p_done !== 1'b1; i++) @(negedge clk);
    chk("done", 2'b10, {p_done, p_err});
    chk("local", 2'b10, {l_done, l_busy});
    if (p_done !== 1'b1) end_sim();
    chk("type", typ, p_typ);
    chk("stream", f ? 3'h0 : stm, p_stm);
    chk("reason", f ? 3'h0 : mdf ? 3'h4 : (!own && ph != 2'h3) ? (itf ? 3'h5 : vrd) : 3'h0,
      p_rsn);
    chk("status", f || ph == 2'h3, p_st);
    chk("owner", !f && own, p_ow);
    chk("tie", {tie0, tie0}, {p_tie, l_tie});
    chk("addr", f ? 16'h0000 : own ? tadr : oadr, p_adr);
    chk("unsafe", |(m & lim), p_uns);
    chk("lunsafe", |(m & lim), l_uns);
    chk("unidir", nak, p_ud);
    chk("wave", (typ == 3'h1 || typ == 3'h2) && ta && ofdm, p_wv);
    chk("beam", beam, p_beam);
    chk("count", n, p_cnt);
    chk("map", m, p_map);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 8; i++) wr(i, 16'h8001 << i, 16'h0003 << (2 * i));
    @(negedge clk);
    newr = 1;
    @(negedge clk);
    newr = 0;
    @(negedge clk);
    tie0 = l_tie;
    // Sweep types, roles, phases, verdicts and counts together
    for (int k = 0; k < 40; k++) begin
      typ = 3'(k % 5); own = k[1]; ph = k[2] ? 2'h3 : {1'b0, k[3]}; vrd = 3'(k % 4);
      stm = k[2:0]; itf = k[4] & k[0]; mdf = (k % 9 == 4); nak = k[0];
      ta = k[3]; ofdm = k[1] | k[4]; beam = 8'(k * 7); cnt = 4'(k % 10);
      tadr = 16'h1000 + 16'(k); oadr = 16'h2000 + 16'(k);
      lim = k[2] ? (256'h1 << (k * 5)) : '0;
      go();
    end
    end_sim();
  end
endmodule
